// ===== tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module tb_top import ure_pkg::*; ;
    logic sys_clk;
    logic rst_n;
    wire rx_pin;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic wr_stb;
    logic rd_stb;
    logic [DATA_W-1:0] rd_data;
    logic rx_error_irq;
    logic [7:0] v;
    int err_total;
    int comparisons;
    int irq_cnt;
    logic [1:0] par_cfg;
    int bit_len;

    ure_rx_err #(.FIFO_DEPTH(8)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .rx_pin(rx_pin), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .rx_error_irq(rx_error_irq));
    ure_tx_model tx (.sys_clk(sys_clk), .line(rx_pin));

    // ----------------------------------------
    // clock, irq pulse counter, watchdog
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (rx_error_irq === 1'b1) begin
            irq_cnt++;
        end
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        err_total++;
        $display("mismatch watchdog expected finish seen timeout");
        end_of_test();
    end

    // ----------------------------------------
    // bus and frame tasks
    // ----------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        rd(a, d);
        `CHK(nm, e, d)
    endtask
    task automatic frame(input logic [7:0] d, input logic bp, input logic bs, input int nirq);
        int i0;
        i0 = irq_cnt;
        tx.send(d, par_cfg[1], par_cfg[0], bp, bs, bit_len);
        `CHK("irq count", i0 + nirq, irq_cnt)
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rchk(OFS_STATUS, 8'h00, "status reset");
        rchk(OFS_ERR_PTR, 8'h00, "pointer reset");
        rchk(3'h7, 8'h00, "unmapped read");
        rchk(OFS_BAUD, BAUD_RST, "baud reset");
        wr(OFS_BAUD, 8'h01);
        rchk(OFS_BAUD, BAUD_RST, "baud refused");
        wr(OFS_BAUD, 8'h04);
        rchk(OFS_BAUD, 8'h04, "baud set");
        wr(OFS_CTRL, 8'hC2);
        $display("test reset done");
    endtask

    task automatic t_single();
        frame(8'hA5, 1'b0, 1'b0, 0);
        rchk(OFS_DATA, 8'hA5, "data good");
        rchk(OFS_STATUS, 8'h00, "status good");
        frame(8'h5A, 1'b1, 1'b0, 1);
        rchk(OFS_STATUS, 8'h04, "status parity");
        rd(OFS_DATA, v);
        frame(8'h81, 1'b0, 1'b1, 1);
        rchk(OFS_STATUS, 8'h06, "status framing");
        rd(OFS_DATA, v);
        wr(OFS_STATUS, 8'h0F);
        rchk(OFS_STATUS, 8'h06, "status all ones");
        wr(OFS_STATUS, 8'h0E);
        rchk(OFS_STATUS, 8'h00, "status cleared");
        frame(8'h3C, 1'b0, 1'b0, 0);
        frame(8'hC3, 1'b0, 1'b0, 1);
        rchk(OFS_STATUS, 8'h01, "status overrun");
        rchk(OFS_DATA, 8'h3C, "data kept");
        rchk(OFS_ERR_PTR, 8'h00, "pointer single");
        wr(OFS_CTRL, 8'h82);
        rchk(OFS_STATUS, 8'h00, "status rx off");
        wr(OFS_CTRL, 8'hC2);
        $display("test single done");
    endtask

    task automatic t_parity();
        par_cfg = 2'b11;
        wr(OFS_CTRL, 8'hC3);
        frame(8'h5A, 1'b0, 1'b0, 0);
        rchk(OFS_STATUS, 8'h00, "odd parity good");
        rchk(OFS_DATA, 8'h5A, "odd parity data");
        frame(8'h5B, 1'b1, 1'b0, 1);
        rchk(OFS_STATUS, 8'h04, "odd parity bad");
        rd(OFS_DATA, v);
        wr(OFS_STATUS, 8'h00);
        par_cfg = 2'b00;
        bit_len = 2;
        wr(OFS_BAUD, 8'h02);
        wr(OFS_CTRL, 8'hC0);
        frame(8'h7E, 1'b1, 1'b0, 0);
        rchk(OFS_STATUS, 8'h00, "no parity");
        rchk(OFS_DATA, 8'h7E, "short bit data");
        bit_len = 4;
        wr(OFS_BAUD, 8'h04);
        par_cfg = 2'b10;
        wr(OFS_CTRL, 8'hC2);
        $display("test parity done");
    endtask

    task automatic t_fifo();
        int n;
        wr(OFS_FIFO_CTRL, 8'h80);
        frame(8'h5A, 1'b1, 1'b0, 1);
        rchk(OFS_ERR_PTR, 8'h02, "pointer parity");
        frame(8'h81, 1'b0, 1'b1, 1);
        rchk(OFS_ERR_PTR, 8'h03, "pointer framing");
        rchk(OFS_STATUS, 8'h00, "status fifo");
        wr(OFS_CTRL, 8'h82);
        rchk(OFS_ERR_PTR, 8'h03, "pointer rx off");
        wr(OFS_CTRL, 8'h02);
        rchk(OFS_ERR_PTR, 8'h00, "pointer power off");
        wr(OFS_CTRL, 8'hC2);
        for (int i = 0; i < 8; i++) begin
            frame(8'h10 + i[7:0], 1'b0, 1'b0, 0);
        end
        n = 0;
        v = 8'h00;
        while (v[LVL_FULL_BIT] !== 1'b1 && n < 20) begin
            rd(OFS_LEVEL, v);
            n++;
        end
        `CHK("fifo full", 1'b1, v[LVL_FULL_BIT])
        frame(8'hEE, 1'b0, 1'b0, 1);
        rchk(OFS_STATUS, 8'h08, "status overflow");
        for (int i = 0; i < 8; i++) begin
            rchk(OFS_DATA, 8'h10 + i[7:0], "fifo data");
        end
        rd(OFS_LEVEL, v);
        `CHK("fifo empty", 1'b1, v[LVL_EMPTY_BIT])
        wr(OFS_STATUS, 8'h07);
        rchk(OFS_STATUS, 8'h00, "status overflow clear");
        $display("test fifo done");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        addr = '0;
        wr_data = '0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        par_cfg = 2'b10;
        bit_len = 4;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_single();
        t_parity();
        t_fifo();
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire

// ===== ure_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module ure_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    ure_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("depth must be a power of two");
        end
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic push;
    logic pop;

    assign f.wready = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
    assign f.rvalid = (wp != rp);
    assign f.rdata = mem[rp[AW-1:0]];
    assign push = f.wvalid && f.wready;
    assign pop = f.rready && f.rvalid;

    // ----------------------------------------
    // pointers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
        end else if (f.flush) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
        end
    end

    // ----------------------------------------
    // storage
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wp[AW-1:0]] <= f.wdata;
        end
    end

    a_fifo_full_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!f.wready && !f.flush) |=> (wp == $past(wp)) && f.rvalid)
        else $error("full fifo took a word");
endmodule // ure_fifo
`default_nettype wire

// ===== ure_fifo_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ure_fifo_if #(parameter int W = 8);
    logic [W-1:0] wdata;
    logic wvalid;
    logic wready;
    logic [W-1:0] rdata;
    logic rvalid;
    logic rready;
    logic flush;
    modport fifo(input wdata, input wvalid, output wready, output rdata,
                 output rvalid, input rready, input flush);
    modport user(output wdata, output wvalid, input wready, input rdata,
                 input rvalid, output rready, output flush);
endinterface // ure_fifo_if
`default_nettype wire

// ===== ure_pkg.sv
package ure_pkg;
    // ----------------------------------------
    // bus geometry
    // ----------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH_DEF = 8;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [2:0] OFS_CTRL = 3'h0;
    localparam logic [2:0] OFS_FIFO_CTRL = 3'h1;
    localparam logic [2:0] OFS_STATUS = 3'h2;
    localparam logic [2:0] OFS_ERR_PTR = 3'h3;
    localparam logic [2:0] OFS_DATA = 3'h4;
    localparam logic [2:0] OFS_BAUD = 3'h5;
    localparam logic [2:0] OFS_LEVEL = 3'h6;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTRL_PWR_BIT = 7;
    localparam int CTRL_RXE_BIT = 6;
    localparam int CTRL_PEN_BIT = 1;
    localparam int CTRL_PODD_BIT = 0;
    localparam int FCTL_MODE_BIT = 7;
    localparam int STAT_OVF_BIT = 3;
    localparam int STAT_PE_BIT = 2;
    localparam int STAT_FE_BIT = 1;
    localparam int STAT_OVE_BIT = 0;
    localparam int PTR_PEF_BIT = 1;
    localparam int PTR_FEF_BIT = 0;
    localparam int LVL_FULL_BIT = 1;
    localparam int LVL_EMPTY_BIT = 0;
    // ----------------------------------------
    // reset values and counts
    // ----------------------------------------
    localparam logic [3:0] STAT_RST = 4'h0;
    localparam logic [3:0] STAT_KEEP = 4'hF;
    localparam logic [1:0] PTR_RST = 2'h0;
    localparam logic [7:0] BAUD_RST = 8'h10;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP
    } ure_state_e;
endpackage

// ===== ure_rx_err.sv
// Operation
// - single mode detects parity, framing, overrun
// - fifo mode detects parity, framing, overflow
// - single mode errors set status flags
// - fifo overflow sets status overflow flag
// - fifo parity/framing set error pointer flags
// - any flag set raises error interrupt
// - software reads error cause from registers
// - zero flag, power or enable clears status
// - only power-off write clears error pointer
// - parity mismatch flags a parity error
// - missing stop bit flags a framing error
// - single: unread previous character means overrun
// - fifo: full unread fifo means overflow
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module ure_rx_err
    import ure_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic rx_pin,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [DATA_W-1:0] rd_data,
    output logic rx_error_irq
);
    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("fifo depth too small");
        end
    end

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic rx_meta;
    logic rx_sync;
    logic power_on;
    logic rx_en;
    logic par_en;
    logic par_odd;
    logic fifo_mode;
    logic [7:0] baud_div;
    ure_state_e state;
    logic [7:0] cnt;
    logic [2:0] bitn;
    logic [7:0] shreg;
    logic par_acc;
    logic rx_done;
    logic [7:0] rx_char;
    logic rx_perr;
    logic rx_ferr;
    logic [7:0] hold_data;
    logic hold_full;
    logic [3:0] status;
    logic [1:0] err_ptr;
    logic active;
    logic wr_ctrl;
    logic pwr_clr;
    logic st_clr;
    logic pop_single;
    logic pe_s;
    logic fe_s;
    logic ove_s;
    logic ovf_s;
    logic pef_s;
    logic fef_s;
    logic set_any;

    ure_fifo_if #(.W(DATA_W)) fq();

    ure_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .f(fq.fifo)
    );

    function automatic logic [7:0] bit_reload(input logic [7:0] d);
        return d - 8'h01;
    endfunction

    function automatic logic is_wr(input logic s, input logic [2:0] a,
                                   input logic [2:0] o);
        return s && (a == o);
    endfunction

    // ----------------------------------------
    // pin synchroniser
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rx_pin;
            rx_sync <= rx_meta;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    assign wr_ctrl = is_wr(wr_stb, addr, OFS_CTRL);
    assign pwr_clr = wr_ctrl && !wr_data[CTRL_PWR_BIT];
    assign active = power_on && rx_en;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_on <= 1'b0;
            rx_en <= 1'b0;
            par_en <= 1'b0;
            par_odd <= 1'b0;
        end else if (wr_ctrl) begin
            power_on <= wr_data[CTRL_PWR_BIT];
            rx_en <= wr_data[CTRL_RXE_BIT];
            par_en <= wr_data[CTRL_PEN_BIT];
            par_odd <= wr_data[CTRL_PODD_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_mode <= 1'b0;
        end else if (is_wr(wr_stb, addr, OFS_FIFO_CTRL)) begin
            fifo_mode <= wr_data[FCTL_MODE_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            baud_div <= BAUD_RST;
        end else if (is_wr(wr_stb, addr, OFS_BAUD) && wr_data > 8'h01) begin
            baud_div <= wr_data;
        end
    end

    // ----------------------------------------
    // character receiver
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cnt <= 8'h00;
            bitn <= 3'h0;
            shreg <= 8'h00;
            par_acc <= 1'b0;
            rx_done <= 1'b0;
            rx_char <= 8'h00;
            rx_perr <= 1'b0;
            rx_ferr <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (!active) begin
                state <= ST_IDLE;
            end else begin
                unique case (state)
                    ST_IDLE: begin
                        if (!rx_sync) begin
                            cnt <= {1'b0, baud_div[7:1]} - 8'h01;
                            rx_perr <= 1'b0;
                            state <= ST_START;
                        end
                    end
                    ST_START: begin
                        if (cnt != 8'h00) begin
                            cnt <= cnt - 8'h01;
                        end else if (rx_sync) begin
                            state <= ST_IDLE;
                        end else begin
                            cnt <= bit_reload(baud_div);
                            bitn <= 3'h0;
                            par_acc <= par_odd;
                            state <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (cnt != 8'h00) begin
                            cnt <= cnt - 8'h01;
                        end else begin
                            shreg <= {rx_sync, shreg[7:1]};
                            par_acc <= par_acc ^ rx_sync;
                            cnt <= bit_reload(baud_div);
                            bitn <= bitn + 3'h1;
                            if (bitn == LAST_DATA_BIT) begin
                                state <= par_en ? ST_PAR : ST_STOP;
                            end
                        end
                    end
                    ST_PAR: begin
                        if (cnt != 8'h00) begin
                            cnt <= cnt - 8'h01;
                        end else begin
                            rx_perr <= par_acc ^ rx_sync;
                            cnt <= bit_reload(baud_div);
                            state <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        if (cnt != 8'h00) begin
                            cnt <= cnt - 8'h01;
                        end else begin
                            rx_ferr <= !rx_sync;
                            rx_char <= shreg;
                            rx_done <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // single buffer and fifo path
    // ----------------------------------------
    assign pop_single = rd_stb && addr == OFS_DATA && !fifo_mode;
    assign fq.wdata = rx_char;
    assign fq.wvalid = rx_done && fifo_mode;
    assign fq.rready = rd_stb && addr == OFS_DATA && fifo_mode;
    assign fq.flush = !power_on;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_data <= 8'h00;
            hold_full <= 1'b0;
        end else if (!power_on) begin
            hold_full <= 1'b0;
        end else if (rx_done && !fifo_mode && (!hold_full || pop_single)) begin
            hold_data <= rx_char;
            hold_full <= 1'b1;
        end else if (pop_single) begin
            hold_full <= 1'b0;
        end
    end

    // ----------------------------------------
    // error detection
    // ----------------------------------------
    assign pe_s = rx_done && !fifo_mode && rx_perr;
    assign fe_s = rx_done && !fifo_mode && rx_ferr;
    assign ove_s = rx_done && !fifo_mode && hold_full && !pop_single;
    assign ovf_s = rx_done && fifo_mode && !fq.wready;
    assign pef_s = rx_done && fifo_mode && rx_perr;
    assign fef_s = rx_done && fifo_mode && rx_ferr;
    assign set_any = pe_s || fe_s || ove_s || ovf_s || pef_s || fef_s;

    assign st_clr = (is_wr(wr_stb, addr, OFS_STATUS) && wr_data[3:0] != STAT_KEEP)
        || (wr_ctrl && (!wr_data[CTRL_PWR_BIT] || !wr_data[CTRL_RXE_BIT]));

    // ----------------------------------------
    // sticky flags, set wins over clear
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= STAT_RST;
        end else begin
            status <= (st_clr ? STAT_RST : status)
                | {ovf_s, pe_s, fe_s, ove_s};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_ptr <= PTR_RST;
        end else begin
            err_ptr <= (pwr_clr ? PTR_RST : err_ptr)
                | {pef_s, fef_s};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_error_irq <= 1'b0;
        end else begin
            rx_error_irq <= set_any;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (rd_stb) begin
            unique case (addr)
                OFS_CTRL: rd_data <= {power_on, rx_en, 4'h0, par_en, par_odd};
                OFS_FIFO_CTRL: rd_data <= {fifo_mode, 7'h00};
                OFS_STATUS: rd_data <= {4'h0, status};
                OFS_ERR_PTR: rd_data <= {6'h00, err_ptr};
                OFS_DATA: rd_data <= fifo_mode ? (fq.rvalid ? fq.rdata : 8'h00) : hold_data;
                OFS_BAUD: rd_data <= baud_div;
                OFS_LEVEL: rd_data <= {6'h00, !fq.wready, !fq.rvalid};
                default: rd_data <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_single_char;
        rx_done && !fifo_mode;
    endsequence

    sequence s_fifo_char;
        rx_done && fifo_mode;
    endsequence

    a_single_parity_flag: assert property (s_single_char ##0 rx_perr
        |=> status[STAT_PE_BIT] && rx_error_irq)
        else $error("parity flag or irq missing");
    a_single_frame_flag: assert property (s_single_char ##0 rx_ferr
        |=> status[STAT_FE_BIT])
        else $error("framing flag missing");
    a_single_overrun_flag: assert property (s_single_char ##0 (hold_full && !pop_single)
        |=> status[STAT_OVE_BIT] && hold_data == $past(hold_data))
        else $error("overrun flag missing");
    a_fifo_overflow_flag: assert property (s_fifo_char ##0 !fq.wready
        |=> status[STAT_OVF_BIT] && rx_error_irq)
        else $error("overflow flag missing");
    a_fifo_ptr_flag: assert property (s_fifo_char ##0 rx_perr
        |=> err_ptr[PTR_PEF_BIT] && rx_error_irq && (!status[STAT_PE_BIT] || $past(status[STAT_PE_BIT])))
        else $error("pointer parity flag missing");
    a_irq_needs_flag: assert property (rx_error_irq |-> (status != STAT_RST || err_ptr != PTR_RST))
        else $error("irq without a flag");
    a_status_clear_write: assert property ((st_clr && !rx_done) |=> status == STAT_RST)
        else $error("status not cleared");
    a_ptr_sticky_hold: assert property ((err_ptr[PTR_FEF_BIT] && !pwr_clr) |=> err_ptr[PTR_FEF_BIT])
        else $error("pointer flag lost");
    a_status_read_back: assert property ((rd_stb && addr == OFS_STATUS)
        |=> rd_data == {4'h0, $past(status)})
        else $error("status read mismatch");
endmodule // ure_rx_err
`default_nettype wire

// ===== ure_tx_model.sv
`timescale 1ns/1ns
`default_nettype none
module ure_tx_model (
    input wire logic sys_clk,
    output logic line
);
    // ----------------------------------------
    // serial frame source, line idles high
    // ----------------------------------------
    initial begin
        line = 1'b1;
    end

    task automatic bit_out(input logic v, input int baud);
        line <= v;
        repeat (baud) @(posedge sys_clk);
    endtask

    // start, 8 data lsb first, optional parity, stop
    task automatic send(input logic [7:0] d, input logic pen, input logic odd, input logic bad_par,
                        input logic bad_stop, input int baud);
        @(posedge sys_clk);
        bit_out(1'b0, baud);
        for (int i = 0; i < 8; i++) begin
            bit_out(d[i], baud);
        end
        if (pen) begin
            bit_out(^d ^ odd ^ bad_par, baud);
        end
        bit_out(~bad_stop, baud);
        line <= 1'b1;
        repeat (3 * baud) @(posedge sys_clk);
    endtask
endmodule // ure_tx_model
`default_nettype wire
